// ---- repeater_regs_pkg.sv ----
// Contract
// (RQ1) sink channel code 10 applies high pre-emphasis
// (RQ2) hotplug test bit 17h[3] clear: normal hotplug
// (RQ3) test mode forces hotplug levels, squelch-gated link
// (RQ4) polarity 0: adapter detected drives output high
// (RQ5) polarity 1: adapter detected drives output low
// (RQ6) override clear: output follows sink adapter input
// (RQ7) override set: input ignored, reports TMDS mode
// (RQ8) hdmi pre-emphasis 18h[3:2]: 00 0dB, 11 2dB
// (RQ9) host never writes vendor test registers
// (RQ10) 1Bh[7] one resets all local registers
// (RQ11) 1Bh[6] one clears config space 103h-10Fh
// (RQ12) 20-bit config address from 1Ch,1Dh,1Eh
// (RQ13) 1Fh reads/writes addressed config location
// (RQ14) 20h[7:1] read-only identity field
// (RQ15) scratch bit reads inverse, 1 after reset
// (RQ16) 22h-27h read-only, writes ignored
// (RQ17) scratch bit sits at 20h bit 0
// (RQ18) 15h[1:0]: 00 none, 01 low pre-emphasis
package repeater_regs_pkg;
  localparam logic [7:0] REG_SINK_TMDS  = 8'h15;
  localparam logic [7:0] REG_HPD_TEST   = 8'h17;
  localparam logic [7:0] REG_HDMI_PRE   = 8'h18;
  localparam logic [7:0] REG_VTEST_A0   = 8'h19;
  localparam logic [7:0] REG_VTEST_A1   = 8'h1A;
  localparam logic [7:0] REG_STROBES    = 8'h1B;
  localparam logic [7:0] REG_ADDR_UPPER = 8'h1C;
  localparam logic [7:0] REG_ADDR_MID   = 8'h1D;
  localparam logic [7:0] REG_ADDR_LOWER = 8'h1E;
  localparam logic [7:0] REG_DATA_WIN   = 8'h1F;
  localparam logic [7:0] REG_IDENTITY   = 8'h20;
  localparam logic [7:0] REG_VTEST_B    = 8'h21;
  localparam logic [7:0] REG_RSVD_FIRST = 8'h22;
  localparam logic [7:0] REG_RSVD_LAST  = 8'h27;

  localparam int HPD_TEST_BIT   = 3;
  localparam int POLARITY_BIT   = 1;
  localparam int OVERRIDE_BIT   = 0;
  localparam int HDMI_PRE_LSB   = 2;
  localparam int SOFT_RESET_BIT = 7;
  localparam int CFG_RESET_BIT  = 6;
  localparam int SCRATCH_BIT    = 0;

  localparam logic [1:0] PRE_NONE     = 2'h0;
  localparam logic [1:0] PRE_LOW      = 2'h1;
  localparam logic [1:0] PRE_HIGH     = 2'h2;
  localparam logic [1:0] HDMI_PRE_2DB = 2'h3;

  localparam logic [1:0] RST_SINK_TMDS = 2'h0;
  localparam logic [2:0] RST_HPD_TEST  = 3'h0;
  localparam logic [1:0] RST_HDMI_PRE  = 2'h0;
  localparam logic [7:0] RST_VTEST     = 8'h00;
  localparam logic [7:0] RST_CFG_ADDR  = 8'h00;
  localparam logic       RST_SCRATCH   = 1'b0;
  localparam logic [7:0] RSVD_READ     = 8'h00;

  localparam logic [19:0] CFG_CLR_FIRST = 20'h00103;
  localparam logic [19:0] CFG_CLR_LAST  = 20'h0010F;

  // arbitrary values, not tied to any real part
  localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h2C;
  localparam logic [6:0] IDENTITY_DEFAULT    = 7'h55;
endpackage

// ---- cfg_space_ram.sv ----
`timescale 1ns/100ps
`default_nettype none
module cfg_space_ram
  import repeater_regs_pkg::*;
#(
  parameter int AW = 9
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_wdata,
  output logic      [7:0]    o_rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  // registered read; old data on a write
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule
`default_nettype wire

// ---- serial_reg_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_reg_port
  import repeater_regs_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEFAULT
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_oe,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  input  wire logic [7:0] i_rdata
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_READ, ST_MACK
  } port_state_t;

  port_state_t state_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic       is_read_r;
  logic       have_ptr_r;
  logic       more_r;
  logic [7:0] ptr_r;
  logic       start_cond;
  logic       stop_cond;
  logic       scl_rise;
  logic       scl_fall;
  logic [7:0] byte_in;

  assign start_cond = i_scl && scl_d_r && sda_d_r && !i_sda;
  assign stop_cond  = i_scl && scl_d_r && !sda_d_r && i_sda;
  assign scl_rise   = i_scl && !scl_d_r;
  assign scl_fall   = !i_scl && scl_d_r;
  assign byte_in    = {shift_r[6:0], i_sda};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= i_scl;
      sda_d_r <= i_sda;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= 3'h0;
      shift_r    <= 8'h00;
      is_read_r  <= 1'b0;
      have_ptr_r <= 1'b0;
      more_r     <= 1'b0;
      ptr_r      <= 8'h00;
      o_sda_oe   <= 1'b0;
      o_wr       <= 1'b0;
      o_rd       <= 1'b0;
      o_addr     <= 8'h00;
      o_wdata    <= 8'h00;
    end else begin
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      if (start_cond) begin
        state_r    <= ST_ADDR;
        bit_cnt_r  <= 3'h0;
        have_ptr_r <= 1'b0;
        o_sda_oe   <= 1'b0;
      end else if (stop_cond) begin
        state_r  <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift_r   <= byte_in;
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                if (shift_r[6:0] == TARGET_ADDR) begin
                  state_r   <= ST_ACK;
                  is_read_r <= i_sda;
                  if (i_sda) begin
                    // fetch early; scl low time hides it
                    o_rd   <= 1'b1;
                    o_addr <= ptr_r;
                    ptr_r  <= ptr_r + 8'h01;
                  end
                end else begin
                  state_r <= ST_IDLE;
                end
              end
            end
          end
          ST_WRITE: begin
            if (scl_rise) begin
              shift_r   <= byte_in;
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                state_r <= ST_ACK;
                if (!have_ptr_r) begin
                  ptr_r      <= byte_in;
                  have_ptr_r <= 1'b1;
                end else begin
                  o_wr    <= 1'b1;
                  o_addr  <= ptr_r;
                  o_wdata <= byte_in;
                  ptr_r   <= ptr_r + 8'h01;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (!o_sda_oe) begin
                o_sda_oe <= 1'b1;
              end else if (is_read_r) begin
                state_r   <= ST_READ;
                shift_r   <= {i_rdata[6:0], 1'b0};
                o_sda_oe  <= !i_rdata[7];
                bit_cnt_r <= 3'h1;
              end else begin
                state_r   <= ST_WRITE;
                o_sda_oe  <= 1'b0;
                bit_cnt_r <= 3'h0;
              end
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              if (bit_cnt_r == 3'h0) begin
                o_sda_oe <= 1'b0;
                state_r  <= ST_MACK;
              end else begin
                o_sda_oe  <= !shift_r[7];
                shift_r   <= {shift_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 3'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              more_r <= !i_sda;
              if (!i_sda) begin
                o_rd   <= 1'b1;
                o_addr <= ptr_r;
                ptr_r  <= ptr_r + 8'h01;
              end
            end else if (scl_fall) begin
              if (more_r) begin
                state_r   <= ST_READ;
                shift_r   <= {i_rdata[6:0], 1'b0};
                o_sda_oe  <= !i_rdata[7];
                bit_cnt_r <= 3'h1;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- repeater_local_ctrl_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module repeater_local_ctrl_regs
  import repeater_regs_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEFAULT,
  parameter logic [6:0] IDENTITY    = IDENTITY_DEFAULT,
  parameter int         CFG_AW      = 9
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  input  wire logic       i_dp_sink_selected,
  input  wire logic       i_dp_sink_hotplug_in,
  input  wire logic       i_tmds_sink_hotplug_in,
  input  wire logic       i_sink_adapter_detect_in,
  input  wire logic       i_source_hotplug_req,
  input  wire logic       i_main_link_request,
  input  wire logic       i_squelch_pass,
  output logic            o_dp_sink_hotplug_eff,
  output logic            o_tmds_sink_hotplug_eff,
  output logic            o_source_hotplug_out,
  output logic            o_main_link_active,
  output logic            o_source_adapter_detect_out,
  output logic      [1:0] o_sink_channel_tmds_preemph,
  output logic            o_hdmi_preemph_2db,
  output logic            o_cfg_reset_busy
);
  logic [1:0]        rst_sync_r;
  logic              rst_n;
  logic              bus_wr;
  logic              bus_rd;
  logic [7:0]        bus_addr;
  logic [7:0]        bus_wdata;
  logic [7:0]        rdata_r;
  logic              rd_d_r;
  logic [7:0]        rd_addr_r;
  logic              win_in_range_d_r;
  logic              soft_reset;
  logic [1:0]        sink_tmds_r;
  logic              hotplug_compliance_test_r;
  logic              adapter_detect_polarity_r;
  logic              adapter_detect_override_r;
  logic [1:0]        hdmi_pre_r;
  logic [7:0]        vtest_r [0:2];
  logic [3:0]        addr_upper_r;
  logic [7:0]        addr_mid_r;
  logic [7:0]        addr_lower_r;
  logic              scratch_r;
  logic [19:0]       cfg_addr;
  logic              cfg_in_range;
  logic              clr_busy_r;
  logic [CFG_AW-1:0] clr_ptr_r;
  logic              mem_we;
  logic [CFG_AW-1:0] mem_addr;
  logic [7:0]        mem_wdata;
  logic [7:0]        mem_rdata;
  logic              adapter_seen;
  logic [7:0]        read_mux;

  // async assert, synchronous release
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // open drain: the enable carries the data
  assign o_sda = 1'b0;

  serial_reg_port #(
    .TARGET_ADDR (TARGET_ADDR)
  ) u_port (
    .i_clk    (i_clk),
    .i_rst_n  (rst_n),
    .i_scl    (i_scl),
    .i_sda    (i_sda),
    .o_sda_oe (o_sda_oe),
    .o_wr     (bus_wr),
    .o_rd     (bus_rd),
    .o_addr   (bus_addr),
    .o_wdata  (bus_wdata),
    .i_rdata  (rdata_r)
  );

  assign soft_reset = bus_wr && bus_addr == REG_STROBES &&
                      bus_wdata[SOFT_RESET_BIT]; // see (RQ10)

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sink_tmds_r <= RST_SINK_TMDS;
    end else if (soft_reset) begin
      sink_tmds_r <= RST_SINK_TMDS; // see (RQ10)
    end else if (bus_wr && bus_addr == REG_SINK_TMDS) begin
      sink_tmds_r <= bus_wdata[1:0]; // see (RQ18)
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      {hotplug_compliance_test_r, adapter_detect_polarity_r,
       adapter_detect_override_r} <= RST_HPD_TEST;
    end else if (soft_reset) begin
      {hotplug_compliance_test_r, adapter_detect_polarity_r,
       adapter_detect_override_r} <= RST_HPD_TEST; // see (RQ2)
    end else if (bus_wr && bus_addr == REG_HPD_TEST) begin
      hotplug_compliance_test_r <= bus_wdata[HPD_TEST_BIT];
      adapter_detect_polarity_r <= bus_wdata[POLARITY_BIT];
      adapter_detect_override_r <= bus_wdata[OVERRIDE_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      hdmi_pre_r <= RST_HDMI_PRE;
    end else if (soft_reset) begin
      hdmi_pre_r <= RST_HDMI_PRE;
    end else if (bus_wr && bus_addr == REG_HDMI_PRE) begin
      hdmi_pre_r <= bus_wdata[HDMI_PRE_LSB+:2]; // see (RQ8)
    end
  end

  // plain storage; host leaves these alone
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        vtest_r[i] <= RST_VTEST;
      end
    end else if (soft_reset) begin
      for (int i = 0; i < 3; i++) begin
        vtest_r[i] <= RST_VTEST;
      end
    end else if (bus_wr) begin
      if (bus_addr == REG_VTEST_A0) begin
        vtest_r[0] <= bus_wdata; // see (RQ9)
      end
      if (bus_addr == REG_VTEST_A1) begin
        vtest_r[1] <= bus_wdata;
      end
      if (bus_addr == REG_VTEST_B) begin
        vtest_r[2] <= bus_wdata;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_upper_r <= RST_CFG_ADDR[3:0];
      addr_mid_r   <= RST_CFG_ADDR;
      addr_lower_r <= RST_CFG_ADDR;
    end else if (soft_reset) begin
      addr_upper_r <= RST_CFG_ADDR[3:0];
      addr_mid_r   <= RST_CFG_ADDR;
      addr_lower_r <= RST_CFG_ADDR;
    end else if (bus_wr) begin
      if (bus_addr == REG_ADDR_UPPER) begin
        addr_upper_r <= bus_wdata[3:0]; // see (RQ12)
      end
      if (bus_addr == REG_ADDR_MID) begin
        addr_mid_r <= bus_wdata;
      end
      if (bus_addr == REG_ADDR_LOWER) begin
        addr_lower_r <= bus_wdata;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      scratch_r <= RST_SCRATCH;
    end else if (soft_reset) begin
      scratch_r <= RST_SCRATCH; // see (RQ15)
    end else if (bus_wr && bus_addr == REG_IDENTITY) begin
      scratch_r <= bus_wdata[SCRATCH_BIT]; // see (RQ17)
    end
  end

  assign cfg_addr     = {addr_upper_r, addr_mid_r, addr_lower_r}; // see (RQ12)
  assign cfg_in_range = (cfg_addr >> CFG_AW) == 20'h00000;

  // one byte a cycle; window writes dropped meanwhile
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_busy_r <= 1'b0;
      clr_ptr_r  <= '0;
    end else if (clr_busy_r) begin
      clr_ptr_r <= clr_ptr_r + 1'b1;
      if (clr_ptr_r == CFG_CLR_LAST[CFG_AW-1:0]) begin
        clr_busy_r <= 1'b0;
      end
    end else if (bus_wr && bus_addr == REG_STROBES &&
                 bus_wdata[CFG_RESET_BIT]) begin
      clr_busy_r <= 1'b1; // see (RQ11)
      clr_ptr_r  <= CFG_CLR_FIRST[CFG_AW-1:0];
    end
  end

  assign mem_we    = clr_busy_r || (bus_wr && bus_addr == REG_DATA_WIN &&
                     cfg_in_range); // see (RQ13)
  assign mem_addr  = clr_busy_r ? clr_ptr_r : cfg_addr[CFG_AW-1:0];
  assign mem_wdata = clr_busy_r ? 8'h00 : bus_wdata;

  cfg_space_ram #(
    .AW (CFG_AW)
  ) u_ram (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_addr  (mem_addr),
    .i_wdata (mem_wdata),
    .o_rdata (mem_rdata)
  );

  always_comb begin
    read_mux = RSVD_READ;
    if (rd_addr_r == REG_SINK_TMDS) begin
      read_mux = {6'h00, sink_tmds_r};
    end else if (rd_addr_r == REG_HPD_TEST) begin
      read_mux = {4'h0, hotplug_compliance_test_r, 1'b0,
                  adapter_detect_polarity_r, adapter_detect_override_r};
    end else if (rd_addr_r == REG_HDMI_PRE) begin
      read_mux = {4'h0, hdmi_pre_r, 2'h0};
    end else if (rd_addr_r == REG_VTEST_A0) begin
      read_mux = vtest_r[0];
    end else if (rd_addr_r == REG_VTEST_A1) begin
      read_mux = vtest_r[1];
    end else if (rd_addr_r == REG_VTEST_B) begin
      read_mux = vtest_r[2];
    end else if (rd_addr_r == REG_ADDR_UPPER) begin
      read_mux = {4'h0, addr_upper_r};
    end else if (rd_addr_r == REG_ADDR_MID) begin
      read_mux = addr_mid_r;
    end else if (rd_addr_r == REG_ADDR_LOWER) begin
      read_mux = addr_lower_r;
    end else if (rd_addr_r == REG_DATA_WIN) begin
      read_mux = win_in_range_d_r ? mem_rdata : 8'h00; // see (RQ13)
    end else if (rd_addr_r == REG_IDENTITY) begin
      read_mux = {IDENTITY, ~scratch_r}; // see (RQ14) see (RQ15)
    end
    // 1Bh and 22h-27h read zero, see (RQ16)
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_d_r           <= 1'b0;
      rd_addr_r        <= 8'h00;
      win_in_range_d_r <= 1'b0;
      rdata_r          <= 8'h00;
    end else begin
      rd_d_r <= bus_rd;
      if (bus_rd) begin
        rd_addr_r        <= bus_addr;
        win_in_range_d_r <= cfg_in_range;
      end
      if (rd_d_r) begin
        rdata_r <= read_mux;
      end
    end
  end

  assign adapter_seen = adapter_detect_override_r ? 1'b1 :
                        i_sink_adapter_detect_in; // see (RQ6) see (RQ7)

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_dp_sink_hotplug_eff       <= 1'b0;
      o_tmds_sink_hotplug_eff     <= 1'b0;
      o_source_hotplug_out        <= 1'b0;
      o_main_link_active          <= 1'b0;
      o_source_adapter_detect_out <= 1'b0;
      o_sink_channel_tmds_preemph <= PRE_NONE;
      o_hdmi_preemph_2db          <= 1'b0;
      o_cfg_reset_busy            <= 1'b0;
    end else begin
      if (hotplug_compliance_test_r) begin
        o_dp_sink_hotplug_eff   <= 1'b1; // see (RQ3)
        o_tmds_sink_hotplug_eff <= 1'b0;
        o_source_hotplug_out    <= 1'b1;
        o_main_link_active      <= i_squelch_pass;
      end else begin
        o_dp_sink_hotplug_eff   <= i_dp_sink_hotplug_in; // see (RQ2)
        o_tmds_sink_hotplug_eff <= i_tmds_sink_hotplug_in;
        o_source_hotplug_out    <= i_source_hotplug_req;
        o_main_link_active      <= i_main_link_request;
      end
      // xor: 0 drives high on detect, 1 low
      o_source_adapter_detect_out <= i_dp_sink_selected &&
        (adapter_seen ^ adapter_detect_polarity_r); // see (RQ4) see (RQ5)
      // reserved 11 falls back to none
      if (i_dp_sink_selected && adapter_seen &&
          (sink_tmds_r == PRE_LOW || sink_tmds_r == PRE_HIGH)) begin
        o_sink_channel_tmds_preemph <= sink_tmds_r; // see (RQ1) see (RQ18)
      end else begin
        o_sink_channel_tmds_preemph <= PRE_NONE;
      end
      o_hdmi_preemph_2db <= hdmi_pre_r == HDMI_PRE_2DB; // see (RQ8)
      o_cfg_reset_busy   <= clr_busy_r;
    end
  end
endmodule
`default_nettype wire

// ---- repeater_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module repeater_props (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_scl,
  input wire logic       i_dp_sink_selected,
  input wire logic       i_dp_sink_hotplug_in,
  input wire logic       i_tmds_sink_hotplug_in,
  input wire logic       i_source_hotplug_req,
  input wire logic       i_main_link_request,
  input wire logic       i_squelch_pass,
  input wire logic       o_dp_sink_hotplug_eff,
  input wire logic       o_tmds_sink_hotplug_eff,
  input wire logic       o_source_hotplug_out,
  input wire logic       o_main_link_active,
  input wire logic       o_source_adapter_detect_out,
  input wire logic [1:0] o_sink_channel_tmds_preemph,
  input wire logic       o_sda_oe,
  input wire logic       o_cfg_reset_busy
);
  // wait out the internal reset
  logic [2:0] up_r;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) up_r <= 3'h0;
    else if (up_r != 3'h4) up_r <= up_r + 3'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_tmds_hp;
    o_tmds_sink_hotplug_eff |-> $past(i_tmds_sink_hotplug_in);
  endproperty
  a_tmds_hp: assert property (p_tmds_hp)
    else $error("tmds hotplug wrong");
  property p_dp_hp;
    up_r == 3'h4 && !o_dp_sink_hotplug_eff |-> !$past(i_dp_sink_hotplug_in);
  endproperty
  a_dp_hp: assert property (p_dp_hp)
    else $error("dp hotplug wrong");
  property p_src_hp;
    up_r == 3'h4 && !o_source_hotplug_out |-> !$past(i_source_hotplug_req);
  endproperty
  a_src_hp: assert property (p_src_hp)
    else $error("source hotplug wrong");
  property p_link;
    o_main_link_active |-> $past(i_main_link_request || i_squelch_pass);
  endproperty
  a_link: assert property (p_link)
    else $error("main link wrong");
  property p_cad_unsel;
    !$past(i_dp_sink_selected) |-> !o_source_adapter_detect_out;
  endproperty
  a_cad_unsel: assert property (p_cad_unsel)
    else $error("adapter detect wrong");
  property p_pre;
    o_sink_channel_tmds_preemph != 2'h0 |->
      $past(i_dp_sink_selected) && o_sink_channel_tmds_preemph != 2'h3;
  endproperty
  a_pre: assert property (p_pre)
    else $error("sink preemph wrong");
  property p_oe;
    $rose(o_sda_oe) |-> !i_scl;
  endproperty
  a_oe: assert property (p_oe)
    else $error("data pulled, clock high");
  property p_busy;
    $rose(o_cfg_reset_busy) |-> o_cfg_reset_busy [*8] ##[1:12] !o_cfg_reset_busy;
  endproperty
  a_busy: assert property (p_busy)
    else $error("clear length wrong");
  c_busy: cover property ($rose(o_cfg_reset_busy));
  c_squelch: cover property (o_main_link_active && !i_main_link_request);
  c_high: cover property (o_sink_channel_tmds_preemph == 2'h2);
endmodule
`default_nettype wire

// ---- host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module host_model
  import repeater_regs_pkg::*;
#(
  parameter logic [6:0] TARGET = TARGET_ADDR_DEFAULT
) (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // released line reads high
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic put(input logic scl, input logic sda, input int n);
    @(posedge i_clk);
    o_scl <= scl;
    o_sda_low <= !sda;
    repeat (n) @(posedge i_clk);
  endtask
  // data moves only while clock is low
  task automatic bit_io(input logic b, output logic s);
    put(1'b0, !o_sda_low, 3);
    put(1'b0, b, 3);
    put(1'b1, b, 4);
    s = i_sda;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic cond(input logic s);
    put(1'b0, !o_sda_low, 3);
    put(1'b0, s, 3);
    put(1'b1, s, 8);
    put(1'b1, !s, 8);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic k;
    cond(1'b1);
    send({TARGET, 1'b0}, k);
    send(a, k);
    send(d, k);
    cond(1'b0);
  endtask
  // pointer, repeated start, one nacked byte
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic k;
    cond(1'b1);
    send({TARGET, 1'b0}, k);
    send(a, k);
    cond(1'b1);
    send({TARGET, 1'b1}, k);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, k);
    cond(1'b0);
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb
  import repeater_regs_pkg::*;
;
  logic i_clk, i_reset_n, scl, sda_low, sda_wire, sda_v, sda_oe;
  logic sel, dp_hp, tmds_hp, cad_in, src_req, link_req, squelch;
  logic dp_eff, tmds_eff, src_out, link_out, cad_out, hdmi2, busy;
  logic [1:0] pre;
  int         checks, miscompares, n;
  assign sda_wire = !(sda_low || (sda_oe && !sda_v));
  repeater_local_ctrl_regs i_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda_wire),
    .o_sda(sda_v), .o_sda_oe(sda_oe), .i_dp_sink_selected(sel),
    .i_dp_sink_hotplug_in(dp_hp), .i_tmds_sink_hotplug_in(tmds_hp),
    .i_sink_adapter_detect_in(cad_in), .i_source_hotplug_req(src_req),
    .i_main_link_request(link_req), .i_squelch_pass(squelch),
    .o_dp_sink_hotplug_eff(dp_eff), .o_tmds_sink_hotplug_eff(tmds_eff),
    .o_source_hotplug_out(src_out), .o_main_link_active(link_out),
    .o_source_adapter_detect_out(cad_out),
    .o_sink_channel_tmds_preemph(pre), .o_hdmi_preemph_2db(hdmi2),
    .o_cfg_reset_busy(busy));
  host_model i_host (
    .i_clk(i_clk), .i_sda(sda_wire), .o_scl(scl), .o_sda_low(sda_low));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.write_reg(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_host.read_reg(a, v);
    chk($sformatf("reg %h", a), v, e);
  endtask
  task automatic settle();
    repeat (4) @(posedge i_clk);
  endtask
  task automatic hp(input logic [3:0] e);
    settle();
    chk("hotplug", {4'h0, dp_eff, tmds_eff, src_out, link_out}, {4'h0, e});
  endtask
  initial begin
    {i_reset_n, sel, dp_hp, tmds_hp, cad_in, src_req, link_req} = 7'h00;
    squelch = 1'b0;
    checks = 0;
    miscompares = 0;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd(REG_SINK_TMDS, 8'h00);
    rd(REG_HPD_TEST, 8'h00);
    rd(REG_HDMI_PRE, 8'h00);
    rd(REG_STROBES, 8'h00);
    rd(REG_IDENTITY, {IDENTITY_DEFAULT, 1'b1});
    rd(8'h30, 8'h00);
    // 19h-1Ah and 21h never written
    for (int a = 0; a < 6; a++) begin
      wr(REG_RSVD_FIRST + 8'(a), 8'hFF);
      rd(REG_RSVD_FIRST + 8'(a), 8'h00);
    end
    wr(REG_IDENTITY, 8'hFF);
    rd(REG_IDENTITY, {IDENTITY_DEFAULT, 1'b0});
    $display("test defaults done");
    // codes 01, 10 never written
    wr(REG_HDMI_PRE, 8'h0C);
    settle();
    chk("hdmi 2db", {7'h00, hdmi2}, 8'h01);
    rd(REG_HDMI_PRE, 8'h0C);
    for (int m = 0; m < 16; m++) begin
      if (m[1:0] == 2'h0) wr(REG_HPD_TEST, {6'h00, m[3], m[2]});
      @(posedge i_clk);
      sel <= m[1];
      cad_in <= m[0];
      settle();
      chk("adapter", {7'h00, cad_out},
          {7'h00, m[1] & ((m[2] | m[0]) ^ m[3])});
    end
    wr(REG_HPD_TEST, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(REG_SINK_TMDS, 8'(c));
      settle();
      chk("sink preemph", {6'h00, pre},
          (c == 1 || c == 2) ? 8'(c) : 8'h00);
    end
    $display("test outputs done");
    @(posedge i_clk);
    tmds_hp <= 1'b1;
    squelch <= 1'b1;
    hp(4'b0100);
    wr(REG_HPD_TEST, 8'h08);
    hp(4'b1011);
    @(posedge i_clk);
    squelch <= 1'b0;
    hp(4'b1010);
    wr(REG_ADDR_MID, 8'h01);
    wr(REG_STROBES, 8'h80);
    hp(4'b0100);
    rd(REG_HDMI_PRE, 8'h00);
    rd(REG_ADDR_MID, 8'h00);
    rd(REG_IDENTITY, {IDENTITY_DEFAULT, 1'b1});
    $display("test soft reset done");
    wr(REG_ADDR_MID, 8'h01);
    wr(REG_ADDR_LOWER, 8'h05);
    wr(REG_DATA_WIN, 8'hA5);
    wr(REG_ADDR_LOWER, 8'h10);
    wr(REG_DATA_WIN, 8'h5A);
    rd(REG_DATA_WIN, 8'h5A);
    wr(REG_ADDR_LOWER, 8'h05);
    rd(REG_DATA_WIN, 8'hA5);
    // upper nibble leaves the populated space
    wr(REG_ADDR_UPPER, 8'h01);
    rd(REG_DATA_WIN, 8'h00);
    rd(REG_ADDR_UPPER, 8'h01);
    wr(REG_ADDR_UPPER, 8'h00);
    wr(REG_STROBES, 8'h40);
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    if (n == 100) miscompares++;
    rd(REG_DATA_WIN, 8'h00);
    wr(REG_ADDR_LOWER, 8'h10);
    rd(REG_DATA_WIN, 8'h5A);
    rd(REG_STROBES, 8'h00);
    $display("test config space done");
    end_of_test();
  end
endmodule
bind repeater_local_ctrl_regs repeater_props i_props (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(i_scl),
  .i_dp_sink_selected(i_dp_sink_selected),
  .i_dp_sink_hotplug_in(i_dp_sink_hotplug_in),
  .i_tmds_sink_hotplug_in(i_tmds_sink_hotplug_in),
  .i_source_hotplug_req(i_source_hotplug_req),
  .i_main_link_request(i_main_link_request),
  .i_squelch_pass(i_squelch_pass),
  .o_dp_sink_hotplug_eff(o_dp_sink_hotplug_eff),
  .o_tmds_sink_hotplug_eff(o_tmds_sink_hotplug_eff),
  .o_source_hotplug_out(o_source_hotplug_out),
  .o_main_link_active(o_main_link_active),
  .o_source_adapter_detect_out(o_source_adapter_detect_out),
  .o_sink_channel_tmds_preemph(o_sink_channel_tmds_preemph),
  .o_sda_oe(o_sda_oe), .o_cfg_reset_busy(o_cfg_reset_busy));
`default_nettype wire
